// ==== core/displaced_store_unit.sv ====
// Guarded displaced halfword/word store unit with status word and APB registers
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module displaced_store_unit (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Issue side
    input  wire logic        st_valid,
    input  wire logic        st_is_word,
    input  wire logic [31:0] st_value,
    input  wire logic [31:0] st_base,
    input  wire logic [6:0]  st_modifier,
    input  wire logic        st_guard_present,
    input  wire logic        st_guard,
    input  wire logic        st_cacheable,
    output logic             st_ready,
    input  wire logic        ijmp_taken,
    output logic             exc_req,
    // Memory and cache side
    output logic             mem_valid,
    output logic      [29:0] mem_word_addr,
    output logic      [3:0]  mem_be,
    output logic      [31:0] mem_wdata,
    output logic             cache_update,
    input  wire logic        mem_ready,
    output logic             irq
);
    function automatic logic is_misaligned(input logic is_word, input logic [1:0] ea_low);
        is_misaligned = is_word ? (ea_low != 2'b00) : ea_low[0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address forming and lane steering
    logic [31:0] disp;
    logic [31:0] ea;
    logic        guard_on;
    logic        accept;
    logic        mis;
    logic [3:0]  lane_be;
    logic [31:0] lane_data;
    logic        psw_le_ff;
    logic        nxt_psw_le;

    // Signed modifier scaled by two or four
    assign disp = st_is_word ? {{23{st_modifier[6]}}, st_modifier, 2'b00}
                             : {{24{st_modifier[6]}}, st_modifier, 1'b0};
    assign ea       = st_base + disp;
    assign guard_on = ~st_guard_present | st_guard;
    assign accept   = st_valid & st_ready;
    assign mis      = is_misaligned(st_is_word, ea[1:0]);

    store_lane_former u_lanes (
        .is_word   (st_is_word),
        .little    (psw_le_ff),
        .ea_low    (ea[1:0]),
        .value     (st_value),
        .lane_be   (lane_be),
        .lane_data (lane_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // State registers
    store_unit_pkg::store_state_t state_ff, nxt_state;
    logic                                 psw_trap_en_ff, nxt_psw_trap_en;
    logic                                 psw_mis_ff, nxt_psw_mis;
    logic                                 trap_pend_ff, nxt_trap_pend;
    logic                                 exc_req_ff, nxt_exc_req;
    logic [store_unit_pkg::IRQ_WIDTH-1:0] irq_stat_ff, nxt_irq_stat;
    logic [store_unit_pkg::IRQ_WIDTH-1:0] irq_en_ff, nxt_irq_en;
    logic                                 irq_ff, nxt_irq;
    logic [31:0]                          store_cnt_ff, nxt_store_cnt;
    logic                                 mem_valid_ff, nxt_mem_valid;
    logic [29:0]                          mem_addr_ff, nxt_mem_addr;
    logic [3:0]                           mem_be_ff, nxt_mem_be;
    logic [31:0]                          mem_wdata_ff, nxt_mem_wdata;
    logic                                 cache_upd_ff, nxt_cache_upd;
    logic                                 st_ready_ff, nxt_st_ready;
    logic                                 pready_ff;
    logic                                 wr_en;
    logic                                 mis_event;
    logic                                 done_event;

    assign st_ready = st_ready_ff;
    assign wr_en    = psel & penable & pready_ff & pwrite;
    assign mis_event  = accept & guard_on & mis;
    assign done_event = mem_valid_ff & mem_ready;

    always_comb begin
        nxt_state       = state_ff;
        nxt_psw_le      = psw_le_ff;
        nxt_psw_trap_en = psw_trap_en_ff;
        nxt_psw_mis     = psw_mis_ff;
        nxt_trap_pend   = trap_pend_ff;
        nxt_exc_req     = 1'b0;
        nxt_irq_stat    = irq_stat_ff;
        nxt_irq_en      = irq_en_ff;
        nxt_store_cnt   = store_cnt_ff;
        nxt_mem_valid   = mem_valid_ff;
        nxt_mem_addr    = mem_addr_ff;
        nxt_mem_be      = mem_be_ff;
        nxt_mem_wdata   = mem_wdata_ff;
        nxt_cache_upd   = cache_upd_ff;
        // Software side, clears first so that hardware sets win
        if (wr_en) begin
            unique case (paddr)
                store_unit_pkg::PSW_OFFSET: begin
                    nxt_psw_le      = pwdata[store_unit_pkg::PSW_LE_BIT];
                    nxt_psw_trap_en = pwdata[store_unit_pkg::PSW_TRAP_EN_BIT];
                    if (pwdata[store_unit_pkg::PSW_MIS_BIT]) begin
                        nxt_psw_mis = 1'b0;
                    end
                end
                store_unit_pkg::IRQ_EN_OFFSET: begin
                    nxt_irq_en = pwdata[store_unit_pkg::IRQ_WIDTH-1:0];
                end
                store_unit_pkg::IRQ_CLR_OFFSET: begin
                    nxt_irq_stat = irq_stat_ff & ~pwdata[store_unit_pkg::IRQ_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end
        // Pending trap is handed over at the next interruptible jump
        if (ijmp_taken & trap_pend_ff) begin
            nxt_exc_req   = 1'b1;
            nxt_trap_pend = 1'b0;
        end
        unique case (state_ff)
            store_unit_pkg::ST_IDLE: begin
                if (accept & guard_on) begin
                    if (mis) begin
                        nxt_psw_mis = 1'b1;
                        if (psw_trap_en_ff) begin
                            nxt_trap_pend = 1'b1;
                        end
                    end else begin
                        nxt_state     = store_unit_pkg::ST_BUSY;
                        nxt_mem_valid = 1'b1;
                        nxt_mem_addr  = ea[31:2];
                        nxt_mem_be    = lane_be;
                        nxt_mem_wdata = lane_data;
                        nxt_cache_upd = st_cacheable;
                    end
                end
            end
            store_unit_pkg::ST_BUSY: begin
                if (mem_ready) begin
                    nxt_state     = store_unit_pkg::ST_IDLE;
                    nxt_mem_valid = 1'b0;
                    nxt_cache_upd = 1'b0;
                    nxt_store_cnt = store_cnt_ff + 32'h0000_0001;
                end
            end
            default: begin
                nxt_state     = store_unit_pkg::ST_IDLE;
                nxt_mem_valid = 1'b0;
                nxt_cache_upd = 1'b0;
            end
        endcase
        if (mis_event) begin
            nxt_irq_stat[store_unit_pkg::IRQ_MIS_BIT] = 1'b1;
        end
        if (done_event) begin
            nxt_irq_stat[store_unit_pkg::IRQ_DONE_BIT] = 1'b1;
        end
        nxt_st_ready = (nxt_state == store_unit_pkg::ST_IDLE);
        nxt_irq      = |(nxt_irq_stat & nxt_irq_en);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff       <= store_unit_pkg::ST_IDLE;
            psw_le_ff      <= store_unit_pkg::PSW_LE_RESET;
            psw_trap_en_ff <= store_unit_pkg::PSW_TRAP_EN_RESET;
            psw_mis_ff     <= 1'b0;
            trap_pend_ff   <= 1'b0;
            exc_req_ff     <= 1'b0;
            irq_stat_ff    <= '0;
            irq_en_ff      <= store_unit_pkg::IRQ_EN_RESET;
            irq_ff         <= 1'b0;
            store_cnt_ff   <= store_unit_pkg::STORE_CNT_RESET;
            mem_valid_ff   <= 1'b0;
            mem_addr_ff    <= '0;
            mem_be_ff      <= '0;
            mem_wdata_ff   <= '0;
            cache_upd_ff   <= 1'b0;
            st_ready_ff    <= 1'b1;
        end else begin
            state_ff       <= nxt_state;
            psw_le_ff      <= nxt_psw_le;
            psw_trap_en_ff <= nxt_psw_trap_en;
            psw_mis_ff     <= nxt_psw_mis;
            trap_pend_ff   <= nxt_trap_pend;
            exc_req_ff     <= nxt_exc_req;
            irq_stat_ff    <= nxt_irq_stat;
            irq_en_ff      <= nxt_irq_en;
            irq_ff         <= nxt_irq;
            store_cnt_ff   <= nxt_store_cnt;
            mem_valid_ff   <= nxt_mem_valid;
            mem_addr_ff    <= nxt_mem_addr;
            mem_be_ff      <= nxt_mem_be;
            mem_wdata_ff   <= nxt_mem_wdata;
            cache_upd_ff   <= nxt_cache_upd;
            st_ready_ff    <= nxt_st_ready;
        end
    end

    assign exc_req       = exc_req_ff;
    assign mem_valid     = mem_valid_ff;
    assign mem_word_addr = mem_addr_ff;
    assign mem_be        = mem_be_ff;
    assign mem_wdata     = mem_wdata_ff;
    assign cache_update  = cache_upd_ff;
    assign irq           = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state, then pready for one cycle
    logic        nxt_pready;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pslverr_ff, nxt_pslverr;

    always_comb begin
        nxt_pready  = psel & penable & ~pready_ff;
        nxt_prdata  = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        if (nxt_pready) begin
            unique case (paddr)
                store_unit_pkg::PSW_OFFSET: begin
                    nxt_prdata[store_unit_pkg::PSW_LE_BIT]      = psw_le_ff;
                    nxt_prdata[store_unit_pkg::PSW_TRAP_EN_BIT] = psw_trap_en_ff;
                    nxt_prdata[store_unit_pkg::PSW_MIS_BIT]     = psw_mis_ff;
                    nxt_prdata[store_unit_pkg::PSW_PEND_BIT]    = trap_pend_ff;
                end
                store_unit_pkg::IRQ_STAT_OFFSET: begin
                    nxt_prdata[store_unit_pkg::IRQ_WIDTH-1:0] = irq_stat_ff;
                end
                store_unit_pkg::IRQ_EN_OFFSET: begin
                    nxt_prdata[store_unit_pkg::IRQ_WIDTH-1:0] = irq_en_ff;
                end
                store_unit_pkg::IRQ_CLR_OFFSET: begin
                    nxt_prdata = 32'h0000_0000;
                end
                store_unit_pkg::STORE_CNT_OFFSET: begin
                    nxt_prdata = store_cnt_ff;
                end
                default: begin
                    nxt_pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= nxt_pready;
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign pready  = pready_ff;
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    logic go;
    assign go = accept & guard_on & ~mis;

    property p_guard_off;
        @(posedge pclk) disable iff (!presetn)
        (accept & ~guard_on) |=> (~mem_valid_ff & ~cache_upd_ff & $stable(psw_mis_ff));
    endproperty
    a_guard_off: assert property (p_guard_off) else $error("False guard store had an effect");

    property p_guard_on;
        @(posedge pclk) disable iff (!presetn)
        go |=> mem_valid_ff ##0 (mem_addr_ff == $past(ea[31:2]));
    endproperty
    a_guard_on: assert property (p_guard_on) else $error("Enabled store not issued at its address");

    property p_mis_half;
        @(posedge pclk) disable iff (!presetn)
        (accept & guard_on & ~st_is_word & ea[0]) |=> (psw_mis_ff & ~mem_valid_ff);
    endproperty
    a_mis_half: assert property (p_mis_half) else $error("Odd halfword store did not flag");

    property p_mis_word;
        @(posedge pclk) disable iff (!presetn)
        (accept & guard_on & st_is_word & (ea[1:0] != 2'b00)) |=> psw_mis_ff;
    endproperty
    a_mis_word: assert property (p_mis_word) else $error("Unaligned word store did not flag");

    property p_trap;
        @(posedge pclk) disable iff (!presetn)
        (trap_pend_ff & ijmp_taken) |=> (exc_req_ff & ~trap_pend_ff);
    endproperty
    a_trap: assert property (p_trap) else $error("Trap not requested at jump");

    property p_half_le;
        @(posedge pclk) disable iff (!presetn)
        (go & ~st_is_word & psw_le_ff) |=>
            (mem_wdata_ff[{$past(ea[1]), 4'h0} +: 16] == $past(st_value[15:0]))
            && (mem_be_ff == ($past(ea[1]) ? 4'hC : 4'h3));
    endproperty
    a_half_le: assert property (p_half_le) else $error("Little endian halfword lanes wrong");

    property p_half_be;
        @(posedge pclk) disable iff (!presetn)
        (go & ~st_is_word & ~psw_le_ff) |=>
            (mem_wdata_ff[{$past(ea[1]), 4'h0} +: 16] == {$past(st_value[7:0]), $past(st_value[15:8])});
    endproperty
    a_half_be: assert property (p_half_be) else $error("Big endian halfword lanes wrong");

    property p_word;
        @(posedge pclk) disable iff (!presetn)
        (go & st_is_word) |=> (mem_be_ff == 4'hF) && (mem_wdata_ff == ($past(psw_le_ff) ? $past(st_value)
            : {$past(st_value[7:0]), $past(st_value[15:8]), $past(st_value[23:16]), $past(st_value[31:24])}));
    endproperty
    a_word: assert property (p_word) else $error("Word store lanes wrong");

    property p_cache;
        @(posedge pclk) disable iff (!presetn)
        (go & st_cacheable) |=> (cache_upd_ff & mem_valid_ff) until_with (mem_valid_ff & mem_ready);
    endproperty
    a_cache: assert property (p_cache) else $error("Cacheable store lost cache update");

    property p_disp;
        @(posedge pclk) disable iff (!presetn)
        (go & st_is_word & (st_modifier == 7'h40)) |=> (mem_addr_ff == $past(st_base[31:2]) - 30'h0000_0040);
    endproperty
    a_disp: assert property (p_disp) else $error("Word displacement not scaled by four");

    c_half: cover property (@(posedge pclk) disable iff (!presetn) go & ~st_is_word ##1 mem_valid_ff & mem_ready);
    c_word: cover property (@(posedge pclk) disable iff (!presetn) go & st_is_word & st_cacheable);
    c_trap: cover property (@(posedge pclk) disable iff (!presetn) exc_req_ff);
    c_skip: cover property (@(posedge pclk) disable iff (!presetn) accept & ~guard_on);
endmodule

// ==== core/store_unit_pkg.sv ====
// Constants, register map and types of the displaced store unit
package store_unit_pkg;
    // Register byte offsets
    localparam logic [11:0] PSW_OFFSET       = 12'h000;
    localparam logic [11:0] IRQ_STAT_OFFSET  = 12'h004;
    localparam logic [11:0] IRQ_EN_OFFSET    = 12'h008;
    localparam logic [11:0] IRQ_CLR_OFFSET   = 12'h00C;
    localparam logic [11:0] STORE_CNT_OFFSET = 12'h010;

    // Status word fields
    localparam int PSW_LE_BIT      = 0;
    localparam int PSW_TRAP_EN_BIT = 1;
    localparam int PSW_MIS_BIT     = 2;
    localparam int PSW_PEND_BIT    = 3;

    // Interrupt event fields
    localparam int IRQ_MIS_BIT  = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam int IRQ_WIDTH    = 2;

    // Reset values
    localparam logic                 PSW_LE_RESET      = 1'b0;
    localparam logic                 PSW_TRAP_EN_RESET = 1'b0;
    localparam logic [IRQ_WIDTH-1:0] IRQ_EN_RESET      = 2'h0;
    localparam logic [31:0]          STORE_CNT_RESET   = 32'h0000_0000;

    // Modifier width
    localparam int MOD_WIDTH = 7;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } store_state_t;
endpackage

// ==== core/store_lane_former.sv ====
// Byte lane steering for halfword and word stores
`timescale 1ns/1ps
module store_lane_former (
    input  wire logic        is_word,
    input  wire logic        little,
    input  wire logic [1:0]  ea_low,
    input  wire logic [31:0] value,
    output logic      [3:0]  lane_be,
    output logic      [31:0] lane_data
);
    genvar l;
    generate
        for (l = 0; l < 4; l++) begin : g_lane
            localparam logic [1:0] LN = 2'(l);
            logic [1:0] word_src;
            logic       half_src;
            logic [1:0] src;
            // Little endian keeps byte j at offset j, big endian mirrors it
            assign word_src = little ? LN : ~LN;
            assign half_src = little ? LN[0] : ~LN[0];
            assign src      = is_word ? word_src : {1'b0, half_src};
            assign lane_be[l] = is_word | (LN[1] == ea_low[1]);
            assign lane_data[8*l +: 8] = value[{src, 3'b000} +: 8];
        end
    endgenerate
endmodule

// ==== verification/store_mem_model.sv ====
// Behavioural data memory and cache model for the store unit's far side
`timescale 1ns/1ps
module store_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        mem_valid,
    input  wire logic [29:0] mem_word_addr,
    input  wire logic [3:0]  mem_be,
    input  wire logic [31:0] mem_wdata,
    input  wire logic        cache_update,
    input  wire logic [3:0]  wait_cycles,
    output logic             mem_ready
);
    logic [7:0] mem [0:255];
    logic [3:0] wait_ff;
    int         writes;
    int         cache_writes;

    initial begin
        writes = 0;
        cache_writes = 0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    end

    ////////////////////////////////////////////////////////////////////////
    // Answer after a programmable number of wait cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ready <= 1'b0;
            wait_ff   <= 4'h0;
        end else if (mem_valid && !mem_ready && wait_ff >= wait_cycles) begin
            mem_ready <= 1'b1;
            wait_ff   <= 4'h0;
        end else begin
            mem_ready <= 1'b0;
            wait_ff   <= (mem_valid && !mem_ready) ? wait_ff + 4'h1 : 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte lanes land at the handshake edge only
    always @(posedge pclk) begin
        if (presetn && mem_valid && mem_ready) begin
            writes++;
            if (cache_update) cache_writes++;
            for (int i = 0; i < 4; i++)
                if (mem_be[i]) mem[{mem_word_addr[5:0], i[1:0]}] = mem_wdata[8*i +: 8];
        end
    end
endmodule

// ==== verification/displaced_store_unit_test.sv ====
// Self-checking testbench of the displaced store unit
`timescale 1ns/1ps
module displaced_store_unit_test;
    logic        pclk, presetn, psel, penable, pwrite, st_valid, st_is_word;
    logic        st_guard_present, st_guard, st_cacheable, ijmp_taken;
    logic [11:0] paddr;
    logic [31:0] pwdata, st_value, st_base, r;
    logic [6:0]  st_modifier;
    logic [3:0]  wait_cycles;
    logic        e;
    wire  [31:0] prdata, mem_wdata;
    wire  [29:0] mem_word_addr;
    wire  [3:0]  mem_be;
    wire         pready, pslverr, st_ready, exc_req, mem_valid, cache_update, mem_ready, irq;
    int          errors, num_checks, w0, c0;

    displaced_store_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .st_valid(st_valid), .st_is_word(st_is_word), .st_value(st_value), .st_base(st_base),
        .st_modifier(st_modifier), .st_guard_present(st_guard_present), .st_guard(st_guard),
        .st_cacheable(st_cacheable), .st_ready(st_ready), .ijmp_taken(ijmp_taken), .exc_req(exc_req),
        .mem_valid(mem_valid), .mem_word_addr(mem_word_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
        .cache_update(cache_update), .mem_ready(mem_ready), .irq(irq));
    store_mem_model mdl (.pclk(pclk), .presetn(presetn), .mem_valid(mem_valid), .mem_word_addr(mem_word_addr),
        .mem_be(mem_be), .mem_wdata(mem_wdata), .cache_update(cache_update), .wait_cycles(wait_cycles),
        .mem_ready(mem_ready));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic lim(input int n);
        if (n >= 50) begin
            errors++;
            report_and_stop();
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        lim(n);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask

    // One guarded store; returns once the unit is idle again
    task automatic store(input logic w, input logic [31:0] v, b, input logic [6:0] m, input logic gp, g, c);
        int n;
        @(posedge pclk);
        st_valid <= 1'b1; st_is_word <= w; st_value <= v; st_base <= b; st_modifier <= m;
        st_guard_present <= gp; st_guard <= g; st_cacheable <= c;
        n = 0;
        do begin @(posedge pclk); n++; end while (st_ready !== 1'b1 && n < 50);
        lim(n);
        st_valid <= 1'b0;
        n = 0;
        do begin @(posedge pclk); n++; end while (!(st_ready === 1'b1 && mem_valid === 1'b0) && n < 50);
        lim(n);
    endtask

    function automatic logic [31:0] mw(input logic [7:0] a);
        return {mdl.mem[a+8'h3], mdl.mem[a+8'h2], mdl.mem[a+8'h1], mdl.mem[a]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0; num_checks = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; st_valid = 1'b0; st_is_word = 1'b0; st_value = 32'h0; st_base = 32'h0;
        st_modifier = 7'h00; st_guard_present = 1'b0; st_guard = 1'b0; st_cacheable = 1'b0; ijmp_taken = 1'b0;
        wait_cycles = 4'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(store_unit_pkg::PSW_OFFSET, 32'h0);
        rd(store_unit_pkg::IRQ_EN_OFFSET, 32'h0);
        rd(store_unit_pkg::STORE_CNT_OFFSET, 32'h0);
        rd(12'h014, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Big-endian stores, done interrupt
        apb(1'b1, store_unit_pkg::IRQ_EN_OFFSET, 32'h3);
        c0 = mdl.cache_writes;
        store(1'b0, 32'h4433_2211, 32'h0000_0CFE, 7'h01, 1'b1, 1'b1, 1'b1);
        chk(mw(8'h00) & 32'hFFFF, 32'h1122);
        chk(mdl.cache_writes - c0, 32'h1);
        rd(store_unit_pkg::IRQ_STAT_OFFSET, 32'h2);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, store_unit_pkg::IRQ_CLR_OFFSET, 32'h3);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        store(1'b1, 32'h4433_2211, 32'h0000_0CFC, 7'h01, 1'b1, 1'b1, 1'b0);
        chk(mw(8'h00), 32'h1122_3344);
        chk(mdl.cache_writes - c0, 32'h1);
        store(1'b1, 32'h0102_0304, 32'h0000_1110, 7'h40, 1'b1, 1'b1, 1'b0);
        chk(mw(8'h10), 32'h0403_0201);
        store(1'b0, 32'h0000_BEEF, 32'h0000_0FA2, 7'h3F, 1'b0, 1'b0, 1'b0);
        chk(mw(8'h20) & 32'hFFFF, 32'hEFBE);
        // False guard, aligned and misaligned
        w0 = mdl.writes;
        c0 = mdl.cache_writes;
        store(1'b1, 32'hFFFF_FFFF, 32'h0000_0D30, 7'h00, 1'b1, 1'b0, 1'b1);
        store(1'b0, 32'hFFFF_FFFF, 32'h0000_0D01, 7'h00, 1'b1, 1'b0, 1'b1);
        chk(mdl.writes - w0, 32'h0);
        chk(mdl.cache_writes - c0, 32'h0);
        rd(store_unit_pkg::PSW_OFFSET, 32'h0);
        // Little-endian stores with a slow memory
        wait_cycles <= 4'h3;
        apb(1'b1, store_unit_pkg::PSW_OFFSET, 32'h1);
        store(1'b0, 32'hAABB_CCDD, 32'h0000_0D06, 7'h7E, 1'b1, 1'b1, 1'b0);
        chk(mw(8'h00) & 32'hFFFF_0000, 32'hCCDD_0000);
        store(1'b1, 32'hAABB_CCDD, 32'h0000_0D0C, 7'h7E, 1'b1, 1'b1, 1'b0);
        chk(mw(8'h04), 32'hAABB_CCDD);
        rd(store_unit_pkg::STORE_CNT_OFFSET, 32'h6);
        // Misaligned halfword: flag, interrupt and mask
        apb(1'b1, store_unit_pkg::IRQ_CLR_OFFSET, 32'h3);
        apb(1'b1, store_unit_pkg::IRQ_EN_OFFSET, 32'h1);
        w0 = mdl.writes;
        store(1'b0, 32'h1234_5678, 32'h0000_0D01, 7'h00, 1'b1, 1'b1, 1'b0);
        rd(store_unit_pkg::PSW_OFFSET, 32'h5);
        chk(mdl.writes - w0, 32'h0);
        rd(store_unit_pkg::IRQ_STAT_OFFSET, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, store_unit_pkg::IRQ_EN_OFFSET, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, store_unit_pkg::PSW_OFFSET, 32'h5);
        rd(store_unit_pkg::PSW_OFFSET, 32'h1);
        // Misaligned word with trap enabled
        apb(1'b1, store_unit_pkg::PSW_OFFSET, 32'h3);
        store(1'b1, 32'h1234_5678, 32'h0000_0D02, 7'h00, 1'b1, 1'b1, 1'b0);
        rd(store_unit_pkg::PSW_OFFSET, 32'hF);
        chk({31'h0, exc_req}, 32'h0);
        @(posedge pclk);
        ijmp_taken <= 1'b1;
        @(posedge pclk);
        ijmp_taken <= 1'b0;
        @(posedge pclk);
        chk({31'h0, exc_req}, 32'h1);
        rd(store_unit_pkg::PSW_OFFSET, 32'h7);
        report_and_stop();
    end
endmodule
